// ### hdl/mmtc_top.sv
// Purpose: 16-bit timer counter with four modes and an APB register file
// Assumes: timer sources are synchronous levels; APB slave answers with no wait
// Notes:   count writes win over a tick in the same cycle; a period write lets the tick step
//
// Contract
// [RULE1] 16-bit count steps up or down on each selected timer tick.
// [RULE2] Clear bit zeroes count, prescaler and latched direction.
// [RULE3] Software count write replaces the count at once.
// [RULE4] Flags only set by counting, never by a software load.
// [RULE5] Source select picks one of two internal and two external clocks.
// [RULE6] Divider passes the source through or divides by two, four, eight.
// [RULE7] Counting only with nonzero mode and a running source.
// [RULE8] Zero period halts up and up/down; nonzero write restarts up from zero.
// [RULE9] Mode field: 00 stop, 01 up, 10 continuous, 11 up/down.
// [RULE10] Up mode counts zero to period then zero; period is value plus one.
// [RULE11] Entering up mode with count above period restarts at zero.
// [RULE12] Up mode: match on reaching period, overflow on period to zero.
// [RULE13] Up mode period change: larger counted to, smaller rolls to zero.
// [RULE14] Continuous wraps at FFFF with overflow; period is plain compare.
// [RULE15] Up/down counts zero to period and back; period twice the value.
// [RULE16] Direction is latched across stops unless cleared.
// [RULE17] Up/down: match on period-1 to period, overflow on 1 to 0.
// [RULE18] Period write while descending takes effect after reaching zero.
// [RULE19] Up/down ascending: larger period counted to, smaller turns down.
// [RULE20] Compare register write updates immediately, no double buffer.
// [RULE21] Software stops the timer before changing configuration.
// [RULE22] Software reads a running async count by majority vote.
// [RULE23] Flag requests interrupt only with own enable and global enable.
// [RULE24] Flags stay set until software clears them.
//
// Our own choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ns
module mmtc_top
   import mmtc_pkg::*;
(
   input  wire logic        i_mclk,
   input  wire logic        i_rst,
   input  wire logic        i_psel,
   input  wire logic        i_penable,
   input  wire logic        i_pwrite,
   input  wire logic [7:0]  i_paddr,
   input  wire logic [31:0] i_pwdata,
   output logic      [31:0] o_prdata,
   output logic             o_pready,
   output logic             o_pslverr,
   input  wire logic        i_aux_clk,
   input  wire logic        i_submain_clk,
   input  wire logic        i_ext_timer_clk,
   input  wire logic        i_second_ext_clk,
   output logic             o_ovf_irq,
   output logic             o_match_irq,
   output logic [15:0]      o_timer_count_value
);
   import mmtc_pkg::*;

   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   logic [10:0] ctrl_q;
   logic [15:0] cnt_q;
   logic [15:0] cnt_d;
   logic [15:0] per_q;
   logic [15:0] lim_q;
   logic [15:0] lim;
   logic        down_q;
   logic        down_d;
   logic        ovf_q;
   logic        match_q;
   logic        ovf_set;
   logic        match_set;
   logic        wr;
   logic        setup;
   logic        hit;
   logic        wr_ctrl;
   logic        wr_stat;
   logic        wr_cnt;
   logic        wr_per;
   logic        clr;
   logic        run;
   logic        step;
   logic [1:0]  mode;
   logic [15:0] inc;
   logic [15:0] dec;
   logic [31:0] rdata;

   mmtc_clk_if clk_if ();

   // ----------------------------------------------------------------
   // apb decode
   // ----------------------------------------------------------------
   assign hit     = (i_paddr == MMTC_OFS_CTRL) || (i_paddr == MMTC_OFS_STAT) ||
                    (i_paddr == MMTC_OFS_COUNT) || (i_paddr == MMTC_OFS_PERIOD);
   assign setup   = i_psel && !i_penable;
   assign wr      = i_psel && i_penable && i_pwrite && hit;
   assign wr_ctrl = wr && (i_paddr == MMTC_OFS_CTRL);
   assign wr_stat = wr && (i_paddr == MMTC_OFS_STAT);
   assign wr_cnt  = wr && (i_paddr == MMTC_OFS_COUNT);
   assign wr_per  = wr && (i_paddr == MMTC_OFS_PERIOD);
   assign clr     = wr_ctrl && i_pwdata[MMTC_CTL_CLR];
   assign o_pready  = 1'b1;
   assign o_pslverr = i_psel && i_penable && !hit;

   // read mux; clear bit always reads zero
   always_comb
   begin
      rdata = 32'h0000_0000;
      case (i_paddr)
         MMTC_OFS_CTRL:   rdata = {21'h00_0000, ctrl_q};
         MMTC_OFS_STAT:   rdata = {29'h0000_0000, down_q, match_q, ovf_q};
         MMTC_OFS_COUNT:  rdata = {16'h0000, cnt_q};
         MMTC_OFS_PERIOD: rdata = {16'h0000, per_q};
         default:         rdata = 32'h0000_0000;
      endcase
   end

   // read data captured in the setup cycle, held through access
   always_ff @(posedge i_mclk)
   begin
      if (i_rst)
         o_prdata <= 32'h0000_0000;
      else if (setup)
         o_prdata <= rdata;
   end

   // ----------------------------------------------------------------
   // control register
   // ----------------------------------------------------------------
   always_ff @(posedge i_mclk)
   begin
      if (i_rst)
         ctrl_q <= MMTC_CTRL_RST;
      else if (wr_ctrl)
         ctrl_q <= i_pwdata[10:0] & ~(11'h001 << MMTC_CTL_CLR); // clear self-resets
   end

   assign mode       = ctrl_q[MMTC_CTL_MODE +: 2];
   assign clk_if.sel = ctrl_q[MMTC_CTL_SRC +: 2];
   assign clk_if.div = ctrl_q[MMTC_CTL_DIV +: 2];
   assign clk_if.clr = clr;

   mmtc_prescaler mmtc_prescaler_i
   (
      .i_mclk (i_mclk),
      .i_rst  (i_rst),
      .i_src  ({i_second_ext_clk, i_ext_timer_clk, i_submain_clk, i_aux_clk}),
      .clk_if (clk_if)
   );

   // ----------------------------------------------------------------
   // period register, written straight through
   // ----------------------------------------------------------------
   always_ff @(posedge i_mclk)
   begin
      if (i_rst)
         per_q <= MMTC_PER_RST;
      else if (wr_per)
         per_q <= i_pwdata[15:0]; // RULE20
   end

   // effective limit: shadow only while descending in up/down
   always_ff @(posedge i_mclk)
   begin
      if (i_rst)
         lim_q <= MMTC_PER_RST;
      else if (!(mode == MMTC_MODE_UPDN && down_q) || (step && cnt_d == 16'h0000))
         lim_q <= per_q; // RULE18
   end

   assign lim = (mode == MMTC_MODE_UPDN && down_q) ? lim_q : per_q;

   // ----------------------------------------------------------------
   // next count and flag events
   // ----------------------------------------------------------------
   // zero period freezes up and up/down without a mode change
   assign run  = (mode == MMTC_MODE_CONT) ||
                 ((mode != MMTC_MODE_STOP) && (per_q != 16'h0000)); // RULE7 RULE8
   assign step = clk_if.tick && run; // RULE7
   assign inc  = cnt_q + 16'h0001;
   assign dec  = cnt_q - 16'h0001;

   always_comb
   begin
      cnt_d     = cnt_q;
      down_d    = down_q;
      ovf_set   = 1'b0;
      match_set = 1'b0;
      case (mode) // RULE9
         MMTC_MODE_UP:
         begin
            if (cnt_q >= lim)
            begin
               cnt_d   = 16'h0000; // RULE10 RULE13
               ovf_set = (cnt_q == lim); // RULE12
            end
            else
            begin
               cnt_d     = inc;
               match_set = (inc == lim); // RULE12
            end
         end
         MMTC_MODE_CONT:
         begin
            cnt_d     = inc; // RULE14
            ovf_set   = (cnt_q == MMTC_CNT_MAX); // RULE14
            match_set = (inc == per_q);
         end
         MMTC_MODE_UPDN:
         begin
            if (down_q)
            begin
               if (cnt_q == 16'h0000)
               begin
                  down_d    = 1'b0;
                  cnt_d     = inc;
                  match_set = (inc == lim);
               end
               else
               begin
                  cnt_d   = dec; // RULE15
                  ovf_set = (cnt_q == 16'h0001); // RULE17
               end
            end
            else if (cnt_q >= lim)
            begin
               down_d = 1'b1; // RULE19
               cnt_d  = dec;
            end
            else
            begin
               cnt_d     = inc;
               match_set = (inc == lim); // RULE17
            end
         end
         default:
         begin
            cnt_d = cnt_q;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // counter and direction
   // ----------------------------------------------------------------
   always_ff @(posedge i_mclk)
   begin
      if (i_rst)
         cnt_q <= MMTC_CNT_RST;
      else if (clr)
         cnt_q <= 16'h0000; // RULE2
      else if (wr_cnt)
         cnt_q <= i_pwdata[15:0]; // RULE3
      else if (wr_ctrl && i_pwdata[MMTC_CTL_MODE +: 2] == MMTC_MODE_UP && cnt_q > per_q)
         cnt_q <= 16'h0000; // RULE11
      else if (wr_per && per_q == 16'h0000 && i_pwdata[15:0] != 16'h0000 &&
               (mode == MMTC_MODE_UP || mode == MMTC_MODE_UPDN))
         cnt_q <= 16'h0000; // RULE8
      else if (step)
         cnt_q <= cnt_d; // RULE1
   end

   // direction survives stop; only clear or restart resets it
   always_ff @(posedge i_mclk)
   begin
      if (i_rst || clr)
         down_q <= 1'b0; // RULE2 RULE16
      else if (wr_per && per_q == 16'h0000 && i_pwdata[15:0] != 16'h0000)
         down_q <= 1'b0; // RULE8
      else if (step && !wr_cnt)
         down_q <= down_d; // RULE16
   end

   // ----------------------------------------------------------------
   // sticky flags; a set in the clearing cycle wins
   // ----------------------------------------------------------------
   always_ff @(posedge i_mclk)
   begin
      if (i_rst)
         ovf_q <= 1'b0;
      else if (step && !wr_cnt && ovf_set)
         ovf_q <= 1'b1; // RULE4 RULE24
      else if (wr_stat && i_pwdata[MMTC_ST_OVF])
         ovf_q <= 1'b0;
   end

   always_ff @(posedge i_mclk)
   begin
      if (i_rst)
         match_q <= 1'b0;
      else if (step && !wr_cnt && match_set)
         match_q <= 1'b1; // RULE4 RULE24
      else if (wr_stat && i_pwdata[MMTC_ST_MATCH])
         match_q <= 1'b0;
   end

   // interrupt requests gated by own and global enables
   assign o_ovf_irq   = ovf_q && ctrl_q[MMTC_CTL_OVFIE] && ctrl_q[MMTC_CTL_GIE]; // RULE23
   assign o_match_irq = match_q && ctrl_q[MMTC_CTL_MATIE] && ctrl_q[MMTC_CTL_GIE]; // RULE23
   assign o_timer_count_value = cnt_q;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (i_rst);

   AST_CLEAR_ZERO: assert property (clr |=> cnt_q == 16'h0000 && !down_q) // RULE2
      else $error("clear did not zero count and direction");
   AST_COUNT_WRITE: assert property (wr_cnt && !clr |=> cnt_q == $past(i_pwdata[15:0])) // RULE3
      else $error("count write not applied");
   AST_NO_FLAG_ON_LOAD: assert property (wr_cnt && !ovf_q |=> !ovf_q) // RULE4
      else $error("overflow set by a software load");
   AST_STOP_HOLD: assert property (mode == MMTC_MODE_STOP && !wr && $stable(mode) // RULE7
                                   |=> $stable(cnt_q))
      else $error("count moved while stopped");
   AST_ZERO_PERIOD: assert property (mode == MMTC_MODE_UP && per_q == 16'h0000 && !wr // RULE8
                                     |=> $stable(cnt_q))
      else $error("count moved with zero period");
   AST_UP_WRAP: assert property (step && !wr && mode == MMTC_MODE_UP && cnt_q == per_q // RULE12
                                 |=> cnt_q == 16'h0000 && ovf_q)
      else $error("up mode did not wrap with overflow");
   AST_CONT_WRAP: assert property (step && !wr && mode == MMTC_MODE_CONT && // RULE14
                                   cnt_q == MMTC_CNT_MAX |=> cnt_q == 16'h0000 && ovf_q)
      else $error("continuous mode wrap wrong");
   AST_UPDN_TURN: assert property (step && !wr && mode == MMTC_MODE_UPDN && !down_q && // RULE15
                                   cnt_q == per_q |=> down_q)
      else $error("up/down did not turn at period");
   AST_UPDN_OVF: assert property (step && !wr && mode == MMTC_MODE_UPDN && down_q && // RULE17
                                  cnt_q == 16'h0001 |=> cnt_q == 16'h0000 && ovf_q)
      else $error("up/down overflow at one to zero missing");
   AST_UPDN_DOWN: assert property (step && !wr && mode == MMTC_MODE_UPDN && down_q && // RULE18
                                   cnt_q != 16'h0000 |=> down_q)
      else $error("up/down left its descent before zero");
   AST_FLAG_STICKY: assert property (match_q && !(wr_stat && i_pwdata[MMTC_ST_MATCH]) // RULE24
                                     |=> match_q)
      else $error("match flag dropped without clear");
   AST_IRQ_GATE: assert property (o_ovf_irq |-> ctrl_q[MMTC_CTL_GIE] && ovf_q) // RULE23
      else $error("overflow request without enable");

   COV_UP_WRAP: cover property (step && mode == MMTC_MODE_UP && ovf_set);
   COV_UPDN_TURN: cover property (step && mode == MMTC_MODE_UPDN && !down_q && down_d);
   COV_CONT_WRAP: cover property (step && mode == MMTC_MODE_CONT && ovf_set);
   COV_SET_CLEAR: cover property (step && ovf_set && wr_stat && i_pwdata[MMTC_ST_OVF]);
endmodule // mmtc_top

// ### hdl/mmtc_pkg.sv
// Purpose: shared constants for the multimode timer counter
// Assumes: APB register map with one aligned 32-bit word per register
// Notes:   offsets are byte addresses
package mmtc_pkg;
   // ----------------------------------------------------------------
   // register offsets
   // ----------------------------------------------------------------
   localparam logic [7:0]  MMTC_OFS_CTRL   = 8'h00;
   localparam logic [7:0]  MMTC_OFS_STAT   = 8'h04;
   localparam logic [7:0]  MMTC_OFS_COUNT  = 8'h08;
   localparam logic [7:0]  MMTC_OFS_PERIOD = 8'h0C;
   // ----------------------------------------------------------------
   // control field positions
   // ----------------------------------------------------------------
   localparam int          MMTC_CTL_SRC    = 0;   // clock_source_select [1:0]
   localparam int          MMTC_CTL_DIV    = 2;   // input_divider_select [3:2]
   localparam int          MMTC_CTL_MODE   = 4;   // count_mode_select [5:4]
   localparam int          MMTC_CTL_CLR    = 6;   // counter_clear_bit, reads 0
   localparam int          MMTC_CTL_OVFIE  = 8;
   localparam int          MMTC_CTL_MATIE  = 9;
   localparam int          MMTC_CTL_GIE    = 10;
   // ----------------------------------------------------------------
   // status field positions
   // ----------------------------------------------------------------
   localparam int          MMTC_ST_OVF     = 0;   // overflow_flag, write 1 clears
   localparam int          MMTC_ST_MATCH   = 1;   // match_flag, write 1 clears
   localparam int          MMTC_ST_DOWN    = 2;   // latched direction, read only
   // ----------------------------------------------------------------
   // modes and reset values
   // ----------------------------------------------------------------
   localparam logic [1:0]  MMTC_MODE_STOP  = 2'h0;
   localparam logic [1:0]  MMTC_MODE_UP    = 2'h1;
   localparam logic [1:0]  MMTC_MODE_CONT  = 2'h2;
   localparam logic [1:0]  MMTC_MODE_UPDN  = 2'h3;
   localparam logic [15:0] MMTC_CNT_MAX    = 16'hFFFF;
   localparam logic [10:0] MMTC_CTRL_RST   = 11'h000;
   localparam logic [15:0] MMTC_CNT_RST    = 16'h0000;
   localparam logic [15:0] MMTC_PER_RST    = 16'h0000;
endpackage

// ### hdl/mmtc_clk_if.sv
// Purpose: carries clock selection and the divided tick between modules
// Assumes: single clock domain
// Notes:   tick is a one-cycle enable pulse
`timescale 1ns/1ns
interface mmtc_clk_if;
   logic [1:0] sel;
   logic [1:0] div;
   logic       clr;
   logic       tick;
   modport ctl (output sel, output div, output clr, input tick);
   modport pre (input sel, input div, input clr, output tick);
endinterface

// ### hdl/mmtc_prescaler.sv
// Purpose: source select, edge detection and divide by 1/2/4/8
// Assumes: source inputs are synchronous levels of i_mclk
// Notes:   a source that stops toggling gives no ticks
`timescale 1ns/1ns
module mmtc_prescaler
(
   input  wire logic       i_mclk,
   input  wire logic       i_rst,
   input  wire logic [3:0] i_src,
   mmtc_clk_if.pre         clk_if
);
   logic [3:0] src_q;
   logic [2:0] div_cnt_q;
   logic [2:0] mask;
   logic       edge_sel;

   // ----------------------------------------------------------------
   // rising edge of the chosen source
   // ----------------------------------------------------------------
   always_ff @(posedge i_mclk)
   begin
      if (i_rst)
         src_q <= 4'h0;
      else
         src_q <= i_src;
   end

   assign edge_sel = i_src[clk_if.sel] & ~src_q[clk_if.sel]; // RULE5

   // divider mask: all ones in the low div bits
   always_comb
   begin
      case (clk_if.div)
         2'h0:    mask = 3'h0;
         2'h1:    mask = 3'h1;
         2'h2:    mask = 3'h3;
         default: mask = 3'h7;
      endcase
   end

   // divider count, cleared by the clear bit
   always_ff @(posedge i_mclk)
   begin
      if (i_rst || clk_if.clr)
         div_cnt_q <= 3'h0; // RULE2
      else if (edge_sel)
         div_cnt_q <= div_cnt_q + 3'h1;
   end

   assign clk_if.tick = edge_sel && ((div_cnt_q & mask) == mask); // RULE6
endmodule // mmtc_prescaler

// ### sim/mmtc_test.sv
// Purpose: self-checking bench for the multimode timer counter
// Assumes: zero-wait APB slave; timer sources are driven as mclk levels
// Notes:   random periods and sources come from a fixed seed
`timescale 1ns/1ns
module mmtc_test;
   import mmtc_pkg::*;
   logic        i_mclk, i_rst, i_psel, i_penable, i_pwrite;
   logic        o_pready, o_pslverr, o_ovf_irq, o_match_irq;
   logic        err_q, m_dir, m_ovf, m_mat;
   logic [3:0]  src_q;
   logic [7:0]  i_paddr;
   logic [15:0] o_timer_count_value, m_cnt, per;
   logic [31:0] i_pwdata, o_prdata, rd_q;
   logic [1:0]  mds [3] = '{MMTC_MODE_UP, MMTC_MODE_CONT, MMTC_MODE_UPDN};
   int          n_fail, n_tests, s;

   // free-running 20 MHz clock
   always #25 i_mclk = ~i_mclk;

   mmtc_top mmtc_top_i
   (
      .i_mclk              (i_mclk),
      .i_rst               (i_rst),
      .i_psel              (i_psel),
      .i_penable           (i_penable),
      .i_pwrite            (i_pwrite),
      .i_paddr             (i_paddr),
      .i_pwdata            (i_pwdata),
      .o_prdata            (o_prdata),
      .o_pready            (o_pready),
      .o_pslverr           (o_pslverr),
      .i_aux_clk           (src_q[0]),
      .i_submain_clk       (src_q[1]),
      .i_ext_timer_clk     (src_q[2]),
      .i_second_ext_clk    (src_q[3]),
      .o_ovf_irq           (o_ovf_irq),
      .o_match_irq         (o_match_irq),
      .o_timer_count_value (o_timer_count_value)
   );

   // ----------------------------------------------------------------
   // checking and bus tasks
   // ----------------------------------------------------------------
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e)
      begin
         n_fail++;
         $display("BAD %s exp %0h got %0h", nm, e, g);
      end
   endtask

   task automatic summarize;
      $display("checks %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // one APB transfer; the extra edge at the end lets register updates land
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      i_psel <= 1'b1;
      i_penable <= 1'b0;
      i_pwrite <= w;
      i_paddr <= a;
      i_pwdata <= d;
      @(posedge i_mclk);
      i_penable <= 1'b1;
      k = 0;
      do
      begin
         @(posedge i_mclk);
         k++;
      end
      while (o_pready !== 1'b1 && k < 16);
      if (k >= 16)
      begin
         n_fail++;
         summarize();
      end
      rd_q = o_prdata;
      err_q = o_pslverr;
      i_psel <= 1'b0;
      i_penable <= 1'b0;
      @(posedge i_mclk);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rc(input logic [7:0] a, input logic [31:0] e, input string nm);
      apb(1'b0, a, 32'h0);
      chk(nm, e, rd_q);
   endtask

   task automatic cfg(input int sr, input int d, input logic [1:0] m, input logic c,
                      input logic [2:0] ie = 3'h0);
      wr(MMTC_OFS_CTRL, 32'(sr) << MMTC_CTL_SRC | 32'(d) << MMTC_CTL_DIV
         | 32'(m) << MMTC_CTL_MODE | 32'(c) << MMTC_CTL_CLR | 32'(ie) << MMTC_CTL_OVFIE);
   endtask

   task automatic cc(input logic [15:0] e);
      chk("count", {16'h0000, e}, {16'h0000, o_timer_count_value});
   endtask

   // n rising edges on one source, each level held for whole mclk cycles
   task automatic tk(input int sr, input int n);
      repeat (n)
      begin
         src_q[sr] <= 1'b1;
         @(posedge i_mclk);
         src_q[sr] <= 1'b0;
         repeat (3) @(posedge i_mclk);
      end
   endtask

   // reference step of the counter for one timer tick
   task automatic mstep(input logic [1:0] md);
      if (md == MMTC_MODE_CONT)
      begin
         m_cnt = m_cnt + 16'h0001;
         m_ovf |= (m_cnt == 16'h0000);
         m_mat |= (m_cnt == per);
      end
      else if (md == MMTC_MODE_UP)
      begin
         m_ovf |= (m_cnt == per);
         m_cnt = (m_cnt >= per) ? 16'h0000 : m_cnt + 16'h0001;
         m_mat |= (m_cnt == per);
      end
      else if (!m_dir && m_cnt < per)
      begin
         m_cnt = m_cnt + 16'h0001;
         m_mat |= (m_cnt == per);
      end
      else if (!m_dir || m_cnt != 16'h0000)
      begin
         m_dir = 1'b1;
         m_cnt = m_cnt - 16'h0001;
         m_ovf |= (m_cnt == 16'h0000);
      end
      else
      begin
         m_dir = 1'b0;
         m_cnt = 16'h0001;
      end
   endtask

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial
   begin
      i_mclk = 1'b0;
      i_rst = 1'b1;
      i_psel = 1'b0;
      i_penable = 1'b0;
      i_pwrite = 1'b0;
      i_paddr = 8'h00;
      i_pwdata = 32'h0;
      src_q = 4'h0;
      n_fail = 0;
      n_tests = 0;
      void'($urandom(32'hE189A683));
      repeat (5) @(posedge i_mclk);
      i_rst <= 1'b0;
      @(posedge i_mclk);
      rc(MMTC_OFS_CTRL, 32'h0, "ctrl");
      rc(MMTC_OFS_STAT, 32'h0, "stat");
      rc(MMTC_OFS_COUNT, 32'h0, "count");
      rc(8'h10, 32'h0, "unmapped");
      chk("slverr", 32'h1, {31'h0, err_q});
      $display("test reset done");
      // the next source in turn must not count; divider restarts on clear
      for (int sr = 0; sr < 4; sr++)
         for (int d = 0; d < 4; d++)
         begin
            cfg(sr, d, MMTC_MODE_CONT, 1'b1);
            tk((sr + 1) % 4, 3);
            cc(16'h0000);
            tk(sr, 8);
            cc(16'(8 >> d));
         end
      // clear mid-division restarts the divide by eight
      cfg(0, 3, MMTC_MODE_CONT, 1'b1);
      tk(0, 5);
      cfg(0, 3, MMTC_MODE_CONT, 1'b1);
      tk(0, 7);
      cc(16'h0000);
      tk(0, 1);
      cc(16'h0001);
      cfg(3, 0, MMTC_MODE_STOP, 1'b0);
      tk(3, 2);
      cc(16'h0001);
      $display("test source done");
      // random runs in each counting mode against the reference step
      for (int i = 0; i < 3; i++)
      begin
         s = $urandom % 4;
         per = 16'(2 + $urandom % 6);
         cfg(s, 0, MMTC_MODE_STOP, 1'b1);
         wr(MMTC_OFS_STAT, 32'h3);
         wr(MMTC_OFS_PERIOD, {16'h0, per});
         rc(MMTC_OFS_PERIOD, {16'h0, per}, "period");
         m_cnt = (mds[i] == MMTC_MODE_CONT) ? MMTC_CNT_MAX - 16'($urandom % 4) : per;
         cfg(s, 0, mds[i], 1'b0);
         wr(MMTC_OFS_COUNT, {16'h0, m_cnt});
         cc(m_cnt);
         rc(MMTC_OFS_STAT, 32'h0, "stat");
         if (mds[i] != MMTC_MODE_CONT)
            m_cnt = 16'h0000;
         wr(MMTC_OFS_COUNT, {16'h0, m_cnt});
         m_dir = 1'b0;
         m_ovf = 1'b0;
         m_mat = 1'b0;
         repeat (3 * per + 3)
         begin
            tk(s, 1);
            mstep(mds[i]);
            cc(m_cnt);
         end
         apb(1'b0, MMTC_OFS_STAT, 32'h0);
         chk("flags", {30'h0, m_mat, m_ovf}, {30'h0, rd_q[1:0]});
         wr(MMTC_OFS_STAT, 32'h3);
         apb(1'b0, MMTC_OFS_STAT, 32'h0);
         chk("flags", 32'h0, {30'h0, rd_q[1:0]});
      end
      $display("test modes done");
      // up/down: latched direction, period change while descending and ascending
      cfg(0, 0, MMTC_MODE_STOP, 1'b1);
      wr(MMTC_OFS_PERIOD, 32'h4);
      cfg(0, 0, MMTC_MODE_UPDN, 1'b0);
      tk(0, 6);
      cc(16'h0002);
      apb(1'b0, MMTC_OFS_STAT, 32'h0);
      chk("dir", 32'h1, {31'h0, rd_q[MMTC_ST_DOWN]});
      cfg(0, 0, MMTC_MODE_STOP, 1'b0);
      tk(0, 2);
      cc(16'h0002);
      rc(MMTC_OFS_COUNT, 32'h2, "count");
      cfg(0, 0, MMTC_MODE_UPDN, 1'b0);
      tk(0, 1);
      cc(16'h0001);
      wr(MMTC_OFS_PERIOD, 32'h8);
      tk(0, 1);
      cc(16'h0000);
      tk(0, 8);
      cc(16'h0008);
      cfg(0, 0, MMTC_MODE_STOP, 1'b1);
      cc(16'h0000);
      rc(MMTC_OFS_STAT, 32'h3, "stat");
      cfg(0, 0, MMTC_MODE_UPDN, 1'b0);
      tk(0, 4);
      wr(MMTC_OFS_PERIOD, 32'h2);
      tk(0, 1);
      cc(16'h0003);
      $display("test updown done");
      // up mode: shrinking period, entry above period, zero period halt
      cfg(0, 0, MMTC_MODE_STOP, 1'b1);
      wr(MMTC_OFS_PERIOD, 32'h8);
      cfg(0, 0, MMTC_MODE_UP, 1'b0);
      tk(0, 6);
      wr(MMTC_OFS_PERIOD, 32'h3);
      tk(0, 1);
      cc(16'h0000);
      cfg(0, 0, MMTC_MODE_STOP, 1'b0);
      wr(MMTC_OFS_COUNT, 32'h14);
      cfg(0, 0, MMTC_MODE_UP, 1'b0);
      cc(16'h0000);
      tk(0, 2);
      wr(MMTC_OFS_PERIOD, 32'h0);
      tk(0, 2);
      cc(16'h0002);
      wr(MMTC_OFS_PERIOD, 32'h5);
      cc(16'h0000);
      tk(0, 1);
      cc(16'h0001);
      $display("test period done");
      // interrupt gating by own enable and global enable
      cfg(0, 0, MMTC_MODE_STOP, 1'b1);
      wr(MMTC_OFS_STAT, 32'h3);
      wr(MMTC_OFS_PERIOD, 32'h1);
      cfg(0, 0, MMTC_MODE_UP, 1'b0);
      tk(0, 2);
      for (int ie = 0; ie < 8; ie++)
      begin
         cfg(0, 0, MMTC_MODE_STOP, 1'b0, 3'(ie));
         chk("ovf_irq", 32'(ie[0] & ie[2]), {31'h0, o_ovf_irq});
         chk("match_irq", 32'(ie[1] & ie[2]), {31'h0, o_match_irq});
      end
      apb(1'b0, MMTC_OFS_STAT, 32'h0);
      chk("flags", 32'h3, {30'h0, rd_q[1:0]});
      $display("test irq done");
      summarize();
   end
endmodule // mmtc_test
